// ===== verilog/fcb_defs.vh
// Purpose: Shared constants for the FIR coefficient bank controller.
// Assumes: 40 MHz system clock; command bytes come from a serial control front end.
// Notes:   Offsets, field positions, reset values and timing counts live here; the coefIdx offsets and play mode reset are coded in the controller.
`ifndef FCB_DEFS_VH
`define FCB_DEFS_VH

// Command bytes
`define FCB_CMD_WR_COEF       8'h30
`define FCB_CMD_RD_COEF       8'h20
`define FCB_CMD_LD_COEF_CNT   8'h13
`define FCB_CMD_LD_FILTER_CONTROL      8'h14

// Filter control layout
`define FCB_FILTER_CONTROL_SWREQ_BIT   4
`define FCB_FILTER_CONTROL_SH_HI_BIT   3
`define FCB_FILTER_CONTROL_SH_LO_BIT   2
`define FCB_FILTER_CONTROL_RESET       8'h0B

// Coefficient address counter
`define FCB_CNT_W             5
`define FCB_CNT_RESET         5'h00
`define FCB_MAIN_LAST         5'h09
`define FCB_AUX_FIRST         5'h10
`define FCB_AUX_LAST          5'h19
`define FCB_TAPS              10
`define FCB_TAP_LAST_LOW      4'h9

// Shift field codes
`define FCB_SH_DIV1           2'h0
`define FCB_SH_DIV2           2'h1
`define FCB_SH_DIV4           2'h2
`define FCB_SH_DIV8           2'h3

// Least reset pulse the controlling party must give
`define FCB_CLK_PERIOD_NS     25
`define FCB_RST_MIN_NS        15000
`define FCB_RST_MIN_CYC       ((`FCB_RST_MIN_NS + `FCB_CLK_PERIOD_NS - 1) / `FCB_CLK_PERIOD_NS)

`endif

// ===== verilog/fcb_scaler.v
// Purpose: Scales one FIR result by a selectable power of two and wraps it to a byte.
// Assumes: FIR result is two's complement and arrives with a one-cycle valid.
// Notes:   Division is an arithmetic shift, so negative results round toward minus infinity.
`timescale 1ns/10ps
`default_nettype none
`include "fcb_defs.vh"

module fcb_scaler #(
  parameter RES_W = 16
) (
  // Clock and control
  input  wire              clk,
  input  wire              rst_n,
  input  wire              ce,
  // Scale selection
  input  wire [1:0]        shiftSel,
  // Raw result
  input  wire              firValid,
  input  wire [RES_W-1:0]  firResult,
  // Scaled result
  output reg  [7:0]        scaled_r,
  output reg               scaledValid_r
);

  reg  [RES_W-1:0] shifted;   // Result after the divide

  // Divide by 1, 2, 4 or 8
  always @*
  begin
    case (shiftSel)
      `FCB_SH_DIV1: shifted = firResult;
      `FCB_SH_DIV2: shifted = $signed(firResult) >>> 1;
      `FCB_SH_DIV4: shifted = $signed(firResult) >>> 2;
      `FCB_SH_DIV8: shifted = $signed(firResult) >>> 3;
      default:      shifted = firResult;
    endcase
  end

  // Keep only the low byte, which is the modulo 256 wrap
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      scaled_r      <= 8'h00;
      scaledValid_r <= 1'b0;
    end
    else if (ce)
    begin
      scaledValid_r <= firValid;
      if (firValid)
        scaled_r <= shifted[7:0];
    end
  end

endmodule
`default_nettype wire

// ===== verilog/fcb_ctrl.v
// Purpose: FIR coefficient banks, address counter, bank switch and output scaling.
// Assumes: Command and data bytes arrive already deserialised, on this clock.
// Notes:   Coefficients keep their contents through reset; only control state clears.
//
// Notes on behaviour
// - Scale FIR result by shift field, wrap 256.
// - Ten shared 8-bit taps for all main channels.
// - Main taps sit at addresses 0 to 9.
// - Ten auxiliary taps at addresses 16 to 25.
// - Host writes buffer bank, reads active bank.
// - Switched flag: set on swap, cleared by main write.
// - Device clears switch request when swap happens.
// - Five-bit address counter, resets to zero.
// - Reset restores defaults, keeps coefficient contents.
// - Swap only at program end after tap 9.
// - Control: request bit4, shift bits3-2, reset 0x0B.
// - Commands: write stream, read stream, load counter, load filter control.
`timescale 1ns/10ps
`default_nettype none
`include "fcb_defs.vh"

module fcb_ctrl #(
  parameter RES_W = 16
) (
  // Clock, reset, enable
  input  wire              clk,
  input  wire              rst_n,
  input  wire              ce,
  // Command and stream bytes from the control front end
  input  wire              cmdStrobe,
  input  wire [7:0]        cmdByte,
  input  wire              wrStrobe,
  input  wire [7:0]        wrByte,
  input  wire              rdStrobe,
  // Read stream answer
  output reg  [7:0]        rdData_r,
  output reg               rdValid_r,
  // Status and control view
  output reg               bankSwitchedFlag_r,
  output reg               switchReq_r,
  output reg  [1:0]        scaleShift_r,
  output reg  [4:0]        coefAddressCounter_r,
  output reg               activeBank_r,
  output reg               defaultPlayMode_r,
  // Filter sequencer side
  input  wire              firProgEnd,
  input  wire [4:0]        tapAddr,
  output reg  [7:0]        tapCoef_r,
  input  wire              firValid,
  input  wire [RES_W-1:0]  firResult,
  output wire [7:0]        scaledOut,
  output wire              scaledValid
);

  // Command states
  localparam [2:0] ST_IDLE  = 3'd0;   // Waiting for a command
  localparam [2:0] ST_WRSTR = 3'd1;   // Streaming into the buffer bank
  localparam [2:0] ST_RDSTR = 3'd2;   // Streaming out of the active bank
  localparam [2:0] ST_LDCNT = 3'd3;   // Next byte loads the counter
  localparam [2:0] ST_LDFC  = 3'd4;   // Next byte loads filter control

  localparam NENT = 4 * `FCB_TAPS;    // Two banks, main plus auxiliary
  localparam [7:0] FILTER_CONTROL_RST = `FCB_FILTER_CONTROL_RESET;   // Control reset image, read by field

  reg  [2:0]  state_r;                // Command state
  reg  [2:0]  state_nxt;
  reg         tap9Seen_r;             // Tap 9 landed since last swap
  reg  [7:0]  coefMem [0:NENT-1];     // Both banks, no reset on purpose

  wire [5:0]  wrIdx;                  // Buffer entry of counter address
  wire [5:0]  rdIdx;                  // Active entry of counter address
  wire [5:0]  tapIdx;                 // Active entry of filter tap
  wire        cntValid;               // Counter points at a real tap
  wire        tapValid;               // Filter tap address is real
  wire        wrHit;                  // A byte goes into the buffer bank
  wire        rdHit;                  // A byte is read out
  wire        mainHit;                // Complete main coefficient written
  wire        tap9Hit;                // Complete tap 9 written
  wire        doSwap;                 // Bank switch this cycle
  wire        cmdFctrl;               // Control byte taken this cycle

  // Map a 5-bit address and bank to a storage index
  function [5:0] coefIdx;
    input       bank;
    input [4:0] addr;
    reg   [5:0] base;
    begin
      base    = bank ? 6'd20 : 6'd0;
      coefIdx = base + (addr[4] ? 6'd10 : 6'd0) + {2'b00, addr[3:0]};
    end
  endfunction

  // Only 0..9 and 16..25 hold taps; the rest of the map is a hole
  function isTap;
    input [4:0] addr;
    begin
      isTap = (addr[3:0] <= `FCB_TAP_LAST_LOW) && !(addr[3:0] > 4'h9);
    end
  endfunction

  assign cntValid = isTap(coefAddressCounter_r);
  assign tapValid = isTap(tapAddr);
  assign wrIdx    = coefIdx(~activeBank_r, coefAddressCounter_r);
  assign rdIdx    = coefIdx(activeBank_r, coefAddressCounter_r);
  assign tapIdx   = coefIdx(activeBank_r, tapAddr);
  assign wrHit    = (state_r == ST_WRSTR) && wrStrobe && !cmdStrobe;
  assign rdHit    = (state_r == ST_RDSTR) && rdStrobe && !cmdStrobe;
  assign mainHit  = wrHit && !coefAddressCounter_r[4] && cntValid;
  assign tap9Hit  = wrHit && (coefAddressCounter_r[3:0] == `FCB_TAP_LAST_LOW);
  assign cmdFctrl = (state_r == ST_LDFC) && wrStrobe && !cmdStrobe;
  // Swap waits for the end of the filter program and a full tap 9
  assign doSwap   = firProgEnd && switchReq_r && tap9Seen_r;

  // Command decoding; a new command always wins over a stream byte
  always @*
  begin
    state_nxt = state_r;
    if (cmdStrobe)
    begin
      case (cmdByte)
        `FCB_CMD_WR_COEF:     state_nxt = ST_WRSTR;
        `FCB_CMD_RD_COEF:     state_nxt = ST_RDSTR;
        `FCB_CMD_LD_COEF_CNT: state_nxt = ST_LDCNT;
        `FCB_CMD_LD_FILTER_CONTROL:    state_nxt = ST_LDFC;
        default:              state_nxt = ST_IDLE;
      endcase
    end
    else if (wrStrobe && (state_r == ST_LDCNT || state_r == ST_LDFC))
      state_nxt = ST_IDLE;
  end

  // Command state and default play mode after reset
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r           <= ST_IDLE;
      defaultPlayMode_r <= 1'b1;
    end
    else if (ce)
      state_r <= state_nxt;
  end

  // Coefficient storage; reset deliberately absent so contents survive
  always @(posedge clk)
  begin
    if (ce && wrHit && cntValid)
      coefMem[wrIdx] <= wrByte;
  end

  // Address counter: loaded by command, steps after each byte
  always @(posedge clk)
  begin
    if (!rst_n)
      coefAddressCounter_r <= `FCB_CNT_RESET;
    else if (ce)
    begin
      if ((state_r == ST_LDCNT) && wrStrobe && !cmdStrobe)
        coefAddressCounter_r <= wrByte[4:0];
      else if (wrHit || rdHit)
        coefAddressCounter_r <= coefAddressCounter_r + 5'd1;
    end
  end

  // Read stream answer, one cycle after the request
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end
    else if (ce)
    begin
      rdValid_r <= rdHit;
      if (rdHit)
        // Holes in the map read as zero
        rdData_r <= cntValid ? coefMem[rdIdx] : 8'h00;
    end
  end

  // Tap lookup for the filter datapath, from the active bank only
  always @(posedge clk)
  begin
    if (!rst_n)
      tapCoef_r <= 8'h00;
    else if (ce)
      tapCoef_r <= tapValid ? coefMem[tapIdx] : 8'h00;
  end

  // Filter control: shift field and the switch request
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      scaleShift_r <= {FILTER_CONTROL_RST[`FCB_FILTER_CONTROL_SH_HI_BIT],
                       FILTER_CONTROL_RST[`FCB_FILTER_CONTROL_SH_LO_BIT]};
      switchReq_r  <= FILTER_CONTROL_RST[`FCB_FILTER_CONTROL_SWREQ_BIT];
    end
    else if (ce)
    begin
      if (cmdFctrl)
      begin
        scaleShift_r <= {wrByte[`FCB_FILTER_CONTROL_SH_HI_BIT],
                         wrByte[`FCB_FILTER_CONTROL_SH_LO_BIT]};
        // A host set in the swap cycle wins over the self clear
        switchReq_r  <= wrByte[`FCB_FILTER_CONTROL_SWREQ_BIT];
      end
      else if (doSwap)
        switchReq_r <= 1'b0;
    end
  end

  // Tap 9 tracking; a fresh tap 9 in the swap cycle stays recorded
  always @(posedge clk)
  begin
    if (!rst_n)
      tap9Seen_r <= 1'b0;
    else if (ce)
    begin
      if (tap9Hit)
        tap9Seen_r <= 1'b1;
      else if (doSwap)
        tap9Seen_r <= 1'b0;
    end
  end

  // Bank select and switched flag; set wins over the main-write clear
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      activeBank_r       <= 1'b0;
      bankSwitchedFlag_r <= 1'b0;
    end
    else if (ce)
    begin
      if (doSwap)
      begin
        activeBank_r       <= ~activeBank_r;
        bankSwitchedFlag_r <= 1'b1;
      end
      else if (mainHit)
        bankSwitchedFlag_r <= 1'b0;
    end
  end

  // Output scaling
  fcb_scaler #(
    .RES_W (RES_W)
  ) fcb_scaler_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .shiftSel      (scaleShift_r),
    .firValid      (firValid),
    .firResult     (firResult),
    .scaled_r      (scaledOut),
    .scaledValid_r (scaledValid)
  );

endmodule
`default_nettype wire

// ===== tb/fcb_assertions.sv
// Purpose: Port checks for the coefficient bank controller
// Assumes: checks pause while ce is low, as the design freezes then
// Notes: Command state is shadowed to know what each byte means
`timescale 1ns/10ps
`default_nettype none
`include "fcb_defs.vh"
module fcb_assertions #(parameter RES_W = 16) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  // Host side
  input wire logic             cmdStrobe,
  input wire logic [7:0]       cmdByte,
  input wire logic             wrStrobe,
  input wire logic [7:0]       wrByte,
  input wire logic             rdStrobe,
  input wire logic             rdValid_r,
  // Status view
  input wire logic             bankSwitchedFlag_r,
  input wire logic             switchReq_r,
  input wire logic [1:0]       scaleShift_r,
  input wire logic [4:0]       coefAddressCounter_r,
  input wire logic             activeBank_r,
  // Filter side
  input wire logic             firProgEnd,
  input wire logic             firValid,
  input wire logic [RES_W-1:0] firResult,
  input wire logic [7:0]       scaledOut,
  input wire logic             scaledValid
);
  logic [2:0]       st_r;    // Shadow state: 1 write, 2 read, 3 count, 4 control
  logic [7:0]       expSc_r; // Expected scaled byte
  wire  [RES_W-1:0] shd   = $signed(firResult) >>> scaleShift_r;
  wire              wrGo  = wrStrobe && !cmdStrobe;
  wire              rdGo  = rdStrobe && !cmdStrobe && st_r == 3'h2;
  // Load states last one byte only, so a stray byte cannot reload
  always @(posedge clk)
  begin
    // Frozen with the design while ce is low
    if (ce)
      expSc_r <= shd[7:0];
    if (!rst_n)
      st_r <= 3'h0;
    else if (!ce)
      st_r <= st_r;
    else if (cmdStrobe)
      st_r <= (cmdByte == `FCB_CMD_WR_COEF)     ? 3'h1 :
              (cmdByte == `FCB_CMD_RD_COEF)     ? 3'h2 :
              (cmdByte == `FCB_CMD_LD_COEF_CNT) ? 3'h3 :
              (cmdByte == `FCB_CMD_LD_FILTER_CONTROL)    ? 3'h4 : 3'h0;
    else if (wrStrobe && st_r > 3'h2)
      st_r <= 3'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);
  scale_value_a: assert property (scaledValid |-> scaledOut == expSc_r)
    else $error("scaled byte wrong");
  scale_valid_a: assert property (firValid |=> scaledValid)
    else $error("scaled valid missing");
  ctl_load_a: assert property (
    st_r == 3'h4 && wrGo |=> ($past(wrByte) >> 2) == {5'h00, switchReq_r, scaleShift_r})
    else $error("control load wrong");
  cnt_load_a: assert property (
    st_r == 3'h3 && wrGo |=> {3'h0, coefAddressCounter_r} == ($past(wrByte) & 8'h1F))
    else $error("counter load wrong");
  cnt_step_a: assert property (
    (st_r == 3'h1 && wrGo) || rdGo |=>
      coefAddressCounter_r == $past(coefAddressCounter_r) + 5'h01)
    else $error("counter step wrong");
  rd_pulse_a: assert property (1'b1 |=> rdValid_r == $past(rdGo))
    else $error("read valid wrong");
  swap_effect_a: assert property (
    $changed(activeBank_r) |-> !switchReq_r && bankSwitchedFlag_r)
    else $error("swap side effects wrong");
  swap_gate_a: assert property (
    $changed(activeBank_r) |-> $past(firProgEnd) && $past(switchReq_r))
    else $error("swap at wrong time");
  flag_clear_a: assert property (
    st_r == 3'h1 && wrGo && coefAddressCounter_r <= `FCB_MAIN_LAST && !firProgEnd
      |=> !bankSwitchedFlag_r)
    else $error("switched flag not cleared");
endmodule
bind fcb_ctrl fcb_assertions #(.RES_W(RES_W)) fcb_assertions_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce),
  .cmdStrobe(cmdStrobe), .cmdByte(cmdByte), .wrStrobe(wrStrobe), .wrByte(wrByte),
  .rdStrobe(rdStrobe), .rdValid_r(rdValid_r), .bankSwitchedFlag_r(bankSwitchedFlag_r),
  .switchReq_r(switchReq_r), .scaleShift_r(scaleShift_r),
  .coefAddressCounter_r(coefAddressCounter_r), .activeBank_r(activeBank_r),
  .firProgEnd(firProgEnd), .firValid(firValid), .firResult(firResult),
  .scaledOut(scaledOut), .scaledValid(scaledValid));
`default_nettype wire

// ===== tb/fcb_host_model.sv
// Purpose: Host side of the control port
// Assumes: Strobes change on the falling edge
// Notes: Released byte lines show the inverse, so stale data cannot pass
`timescale 1ns/10ps
`default_nettype none
module fcb_host_model (
  // Clock
  input  wire logic       clk,
  // Strobes and bytes
  output var  logic       cmdStrobe,
  output var  logic [7:0] cmdByte,
  output var  logic       wrStrobe,
  output var  logic [7:0] wrByte,
  output var  logic       rdStrobe
);
  // Idle lines at time zero
  initial
  begin
    {cmdStrobe, wrStrobe, rdStrobe} = 3'h0;
    {cmdByte, wrByte} = 16'h0000;
  end
  // One command byte, one cycle wide
  task cmd(input logic [7:0] b);
    @(negedge clk) {cmdStrobe, cmdByte} = {1'b1, b};
    @(negedge clk) {cmdStrobe, cmdByte} = {1'b0, ~b};
  endtask
  // One data byte
  task wr(input logic [7:0] b);
    @(negedge clk) {wrStrobe, wrByte} = {1'b1, b};
    @(negedge clk) {wrStrobe, wrByte} = {1'b0, ~b};
  endtask
  // Ask for the next read byte
  task rd;
    @(negedge clk) rdStrobe = 1'b1;
    @(negedge clk) rdStrobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the coefficient bank controller
// Assumes: inputs change on the falling edge; ce drops once near the end
// Notes: Scaler cases are table rows; bank work is hand-written
`timescale 1ns/10ps
`default_nettype none
`include "fcb_defs.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, a); failCount++; end end
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, firProgEnd = 1'b0, firValid = 1'b0;
  logic ce = 1'b1;
  logic [4:0] tapAddr = 5'h00;
  logic [15:0] firResult = 16'h0000;
  wire cmdStrobe, wrStrobe, rdStrobe, rdValid_r, bankSwitchedFlag_r, switchReq_r;
  wire activeBank_r, defaultPlayMode_r, scaledValid;
  wire [7:0] cmdByte, wrByte, rdData_r, tapCoef_r, scaledOut;
  wire [1:0] scaleShift_r;
  wire [4:0] coefAddressCounter_r;
  // Status bits gathered for the reset check
  wire [5:0] resetView = {scaleShift_r, switchReq_r, bankSwitchedFlag_r, activeBank_r,
                          defaultPlayMode_r};
  int failCount = 0, checks = 0;
  // Scaler rows: shift, result, expected byte
  logic [25:0] rows [4] = '{{2'h0, 16'h0123, 8'h23}, {2'h1, 16'h0123, 8'h91},
                           {2'h2, 16'h0FF0, 8'hFC}, {2'h3, 16'hFFF0, 8'hFE}};
  fcb_host_model fcb_host_model_inst (.clk(clk), .cmdStrobe(cmdStrobe), .cmdByte(cmdByte),
    .wrStrobe(wrStrobe), .wrByte(wrByte), .rdStrobe(rdStrobe));
  fcb_ctrl fcb_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .cmdStrobe(cmdStrobe),
    .cmdByte(cmdByte), .wrStrobe(wrStrobe), .wrByte(wrByte), .rdStrobe(rdStrobe),
    .rdData_r(rdData_r), .rdValid_r(rdValid_r), .bankSwitchedFlag_r(bankSwitchedFlag_r),
    .switchReq_r(switchReq_r), .scaleShift_r(scaleShift_r),
    .coefAddressCounter_r(coefAddressCounter_r), .activeBank_r(activeBank_r),
    .defaultPlayMode_r(defaultPlayMode_r), .firProgEnd(firProgEnd),
    .tapAddr(tapAddr), .tapCoef_r(tapCoef_r), .firValid(firValid), .firResult(firResult),
    .scaledOut(scaledOut), .scaledValid(scaledValid));
  initial forever #12.5 clk = ~clk;
  task end_sim;
    if (failCount == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task ctl(input logic [7:0] b);
    fcb_host_model_inst.cmd(`FCB_CMD_LD_FILTER_CONTROL);
    fcb_host_model_inst.wr(b);
  endtask
  task cnt(input logic [4:0] a);
    fcb_host_model_inst.cmd(`FCB_CMD_LD_COEF_CNT);
    fcb_host_model_inst.wr({3'h0, a});
  endtask
  // Ten taps from address a, values v upward
  task wrSet(input logic [4:0] a, input logic [7:0] v);
    cnt(a);
    fcb_host_model_inst.cmd(`FCB_CMD_WR_COEF);
    for (int i = 0; i < 10; i++) fcb_host_model_inst.wr(v + 8'(i));
  endtask
  // Eleven reads: ten taps then the first hole
  task rdChk(input logic [4:0] a, input logic [7:0] v);
    cnt(a);
    fcb_host_model_inst.cmd(`FCB_CMD_RD_COEF);
    for (int i = 0; i < 11; i++) begin
      fcb_host_model_inst.rd();
      `CHK("rdValid", 1'b1, rdValid_r)
      `CHK("rdData", (i < 10) ? v + 8'(i) : 8'h00, rdData_r)
    end
  endtask
  task tap(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk) tapAddr = a;
    @(negedge clk) `CHK("tapCoef", e, tapCoef_r)
  endtask
  task progEnd;
    @(negedge clk) firProgEnd = 1'b1;
    @(negedge clk) firProgEnd = 1'b0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset view", 6'h21, resetView)
    `CHK("counter", 5'h00, coefAddressCounter_r)
    foreach (rows[i]) begin
      ctl({4'h0, rows[i][25:24], 2'h0});
      @(negedge clk) {firValid, firResult} = {1'b1, rows[i][23:8]};
      @(negedge clk) firValid = 1'b0;
      `CHK("scaled", rows[i][7:0], scaledOut)
      `CHK("scaledValid", 1'b1, scaledValid)
    end
    ctl(8'h10);
    progEnd();
    `CHK("early swap", 2'h1, {activeBank_r, switchReq_r})
    wrSet(5'h00, 8'hA0);
    `CHK("counter", 5'h0A, coefAddressCounter_r)
    wrSet(5'h10, 8'hC0);
    `CHK("counter", 5'h1A, coefAddressCounter_r)
    progEnd();
    for (int n = 0; n < 20 && bankSwitchedFlag_r !== 1'b1; n++) @(negedge clk);
    // A swap that never comes is a failure; stop rather than hang
    `CHK("swap wait", 1'b1, bankSwitchedFlag_r)
    if (bankSwitchedFlag_r !== 1'b1) end_sim();
    `CHK("swap", 2'h2, {activeBank_r, switchReq_r})
    ctl(8'h10);
    wrSet(5'h00, 8'h50);
    `CHK("flag", 1'b0, bankSwitchedFlag_r)
    wrSet(5'h10, 8'h70);
    rdChk(5'h00, 8'hA0);
    rdChk(5'h10, 8'hC0);
    tap(5'h19, 8'hC9);
    // Mid-run reset held for the full minimum the board must give
    @(negedge clk) rst_n = 1'b0;
    repeat (`FCB_RST_MIN_CYC) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset bank", 3'h2, {activeBank_r, scaleShift_r})
    rdChk(5'h00, 8'h50);
    tap(5'h09, 8'h59);
    // A control load while ce is low must leave the shift alone
    @(negedge clk) ce = 1'b0;
    ctl(8'h0C);
    @(negedge clk) ce = 1'b1;
    `CHK("frozen shift", 2'h2, scaleShift_r)
    ctl(8'h0C);
    `CHK("shift", 2'h3, scaleShift_r)
    end_sim();
  end
endmodule
`default_nettype wire
